// ==== rr_picker.sv ====
// Round-robin picker among thread request bits.
// Assumes request vector is stable in the cycle it is sampled.
`timescale 1ns/100ps
`default_nettype none
module rr_picker #(
  parameter int N = 4,
  parameter int W = 2
) (
  input  wire logic [N-1:0] req_i,   // Candidate threads
  input  wire logic [W-1:0] last_i,  // Thread granted last
  output logic              any_o,   // Some candidate present
  output logic [W-1:0]      pick_o   // Chosen thread
);
  always_comb begin
    logic [W-1:0] idx;
    idx    = '0;
    any_o  = 1'b0;
    pick_o = '0;
    // Search from the one after last so each thread gets a fair turn
    for (int k = N; k >= 1; k--) begin
      idx = W'(({1'b0, last_i} + (W+1)'(k)) % (W+1)'(N));
      if (req_i[idx]) begin
        any_o  = 1'b1;
        pick_o = idx;
      end
    end
  end
endmodule
`default_nettype wire

// ==== thread_event_flags.sv ====
// Per-thread sticky event flags with set-over-clear.
// Assumes set and clear vectors arrive in the core clock domain.
`timescale 1ns/100ps
`default_nettype none
module thread_event_flags #(
  parameter int NT = 4,
  parameter int NE = 10
) (
  input  wire logic             clk_i,     // Core clock
  input  wire logic             arst_n_i,  // Async reset
  input  wire logic [NT*NE-1:0] set_i,     // Event arrivals
  input  wire logic [NT*NE-1:0] clr_i,     // Clear requests
  output logic      [NT*NE-1:0] flags_o    // Flag state
);
  genvar g;
  generate
    for (g = 0; g < NT*NE; g++) begin : g_flag
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          flags_o[g] <= 1'b0;
        end else begin
          // Arrival wins over a clear in the same cycle
          flags_o[g] <= set_i[g] | (flags_o[g] & ~clr_i[g]);
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== thread_evt_pkg.sv ====
// Shared constants and types for the thread switch and event tracker.
// Assumes a single core clock domain and an AHB-Lite register slave.
`default_nettype none
package thread_evt_pkg;

  localparam int NUM_THREADS = 4;
  localparam int TID_W       = 2;
  localparam int NUM_EVENTS  = 10;
  localparam int EVT_W       = 4;

  // Event flag bit positions
  localparam logic [EVT_W-1:0] EV_FBI      = 4'h0;
  localparam logic [EVT_W-1:0] EV_DMA      = 4'h1;
  localparam logic [EVT_W-1:0] EV_MEM_A    = 4'h2;
  localparam logic [EVT_W-1:0] EV_MEM_B    = 4'h3;
  localparam logic [EVT_W-1:0] EV_ENQ_A    = 4'h4;
  localparam logic [EVT_W-1:0] EV_ENQ_B    = 4'h5;
  localparam logic [EVT_W-1:0] EV_DOORBELL = 4'h6;
  localparam logic [EVT_W-1:0] EV_RX_DONE  = 4'h7;
  localparam logic [EVT_W-1:0] EV_PUSH     = 4'h8;
  localparam logic [EVT_W-1:0] EV_NONE     = 4'h9;

  // Register byte offsets
  localparam logic [7:0] OFS_ENABLE   = 8'h00;
  localparam logic [7:0] OFS_DOORBELL = 8'h04;
  localparam logic [7:0] OFS_CONFIG   = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_EVT0     = 8'h10;
  localparam logic [7:0] OFS_EVT3     = 8'h1c;

  localparam logic [NUM_THREADS-1:0] ENABLE_RST = 4'h0;
  localparam int CFG_FAST_PORT = 0;
  localparam int CFG_AUTOPUSH  = 1;
  localparam int CFG_RX_TID_LO = 2;
  localparam int SWITCH_OVERHEAD_CYC = 1;

  typedef enum logic [2:0] {
    ARB_NONE      = 3'h0,
    ARB_EVENT     = 3'h1,
    ARB_VOLUNTARY = 3'h2,
    ARB_KILL      = 3'h3,
    ARB_SWAP      = 3'h4
  } arb_kind_t;

  // Instruction side request, one per cycle from the running thread
  typedef struct packed {
    logic                 valid;
    arb_kind_t            kind;
    logic [EVT_W-1:0]     event_sel;
    logic                 defer1;
    logic                 br_test;
    logic [EVT_W-1:0]     br_event;
  } ctx_cmd_t;

  // Completion from a shared unit
  typedef struct packed {
    logic             valid;
    logic [EVT_W-1:0] event_sel;
    logic [TID_W-1:0] tid;
  } unit_done_t;

  typedef enum logic [1:0] {
    TS_RUN   = 2'b00,
    TS_SLEEP = 2'b01,
    TS_READY = 2'b11
  } thr_state_t;

endpackage
`default_nettype wire

// ==== thread_switch_event_tracker.sv ====
// Thread scheduler and signal event tracker for a four-thread engine.
// Assumes one instruction per cycle from the pipeline and AHB-Lite host.
//
// What this block does
// - Four threads, each with own run state, awaited event and event flags.
// - A thread switch costs at most one cycle.
// - Deferred arbitrate lets one further instruction run before switching.
// - References never stall the thread; it runs on or sleeps.
// - Only the running thread's own instruction, or a thread becoming ready and enabled while none runs, can cause a switch.
// - Event arbitrate sleeps thread until the named event occurs.
// - Voluntary arbitrate yields to a ready thread, else continues.
// - Kill arbitrate switches away and clears the thread's enable bit.
// - Swap token issues reference, switches, wakes on its completion.
// - Signal-when-done sets completion event without switching.
// - Unit completions set the requesting thread's matching flag.
// - Fast port enqueue increments set that flag in every thread.
// - Doorbell write sets doorbell flag of exactly the named thread.
// - Receive completion sets receive-done of the named thread.
// - Autopush completion sets push-done of the receive scheduler thread.
// - Four separate per-thread event flag registers.
// - Event flag registers writable by host and engine to clear flags.
// - Event branch tests one flag; taken branch clears it.
// - Waking on the awaited event clears that flag.
// - A sleeping thread waits on exactly one event.
// - Next thread chosen round-robin among ready enabled threads.
// - Only enabled threads may be selected.
`timescale 1ns/100ps
`default_nettype none
module thread_switch_event_tracker #(
  parameter int NT = thread_evt_pkg::NUM_THREADS,
  parameter int NE = thread_evt_pkg::NUM_EVENTS
) (
  input  wire logic                      clk_i,        // Core clock
  input  wire logic                      arst_n_i,     // Async reset
  input  wire logic                      hsel_i,       // AHB select
  input  wire logic [7:0]                haddr_i,      // AHB address
  input  wire logic [1:0]                htrans_i,     // AHB transfer
  input  wire logic                      hwrite_i,     // AHB write
  input  wire logic [2:0]                hsize_i,      // AHB size
  input  wire logic [31:0]               hwdata_i,     // AHB write data
  input  wire logic                      hready_i,     // AHB bus ready
  output logic      [31:0]               hrdata_o,     // AHB read data
  output logic                           hreadyout_o,  // AHB ready out
  output logic                           hresp_o,      // AHB response
  input  wire thread_evt_pkg::ctx_cmd_t  cmd_i,        // Running instr
  input  wire thread_evt_pkg::unit_done_t done_i,      // Unit completion
  input  wire logic                      enq_a_i,      // Enqueue count A
  input  wire logic                      enq_b_i,      // Enqueue count B
  input  wire logic                      db_wr_i,      // Thread doorbell
  input  wire logic [1:0]                db_tid_i,     // Doorbell target
  input  wire logic                      rx_done_i,    // Receive finished
  input  wire logic [1:0]                rx_tid_i,     // Receive thread
  input  wire logic                      push_done_i,  // Autopush finished
  input  wire logic                      evt_wr_i,     // Engine flag write
  input  wire logic [1:0]                evt_wr_tid_i, // Engine flag thread
  input  wire logic [NE-1:0]             evt_wr_clr_i, // Engine clear mask
  output logic                           run_vld_o,    // A thread runs
  output logic      [1:0]                run_tid_o,    // Running thread
  output logic                           switch_o,     // Switch this cycle
  output logic                           br_taken_o    // Event branch taken
);

  // ***************************************************************
  // Registers and state
  // ***************************************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  logic [NT-1:0]       enable_r;
  logic [1:0]          cfg_r;
  logic [1:0]          rx_sched_tid_r;
  thread_evt_pkg::thr_state_t state_r [NT];
  logic [3:0]          wait_evt_r [NT];
  logic [1:0]          run_tid_r;
  logic                run_vld_r;
  logic                defer_pend_r;
  logic [2:0]          defer_kind_r;
  logic [3:0]          defer_evt_r;
  logic                dp_vld_r;
  logic                dp_wr_r;
  logic [7:0]          dp_addr_r;
  logic [NT*NE-1:0]    set_v;
  logic [NT*NE-1:0]    clr_v;
  logic [NT*NE-1:0]    flags;
  logic [NT-1:0]       cand;
  logic                pick_any;
  logic [1:0]          pick_tid;
  logic                do_leave;
  logic [2:0]          leave_kind;
  logic [3:0]          leave_evt;
  logic                host_wr;
  logic                yield_ok;
  logic [NT*NE-1:0]    both_v;
  int                  br_idx;

  // ***************************************************************
  // AHB-Lite slave: zero wait states, always OKAY
  // ***************************************************************
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      dp_vld_r  <= 1'b0;
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
    end else begin
      dp_vld_r  <= hsel_i & hready_i &
                   (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
      dp_wr_r   <= hwrite_i;
      dp_addr_r <= haddr_i;
    end
  end

  assign host_wr = dp_vld_r & dp_wr_r;

  // Read data is registered on the address phase so it stands in data phase
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hrdata_o <= 32'h0000_0000;
    end else if (hsel_i & hready_i & ~hwrite_i & htrans_i[1]) begin
      hrdata_o <= 32'h0000_0000;
      case (haddr_i)
        thread_evt_pkg::OFS_ENABLE: hrdata_o <= 32'(enable_r);
        thread_evt_pkg::OFS_CONFIG: hrdata_o <= 32'({rx_sched_tid_r, cfg_r});
        thread_evt_pkg::OFS_STATUS: hrdata_o <= 32'({run_vld_r, run_tid_r});
        default: begin
          if (haddr_i >= thread_evt_pkg::OFS_EVT0 &&
              haddr_i <= thread_evt_pkg::OFS_EVT3) begin
            hrdata_o <= 32'(flags[haddr_i[3:2]*NE +: NE]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_r          <= 2'h0;
      rx_sched_tid_r <= 2'h0;
    end else if (host_wr && dp_addr_r == thread_evt_pkg::OFS_CONFIG) begin
      cfg_r          <= hwdata_i[1:0];
      rx_sched_tid_r <= hwdata_i[thread_evt_pkg::CFG_RX_TID_LO +: 2];
    end
  end

  // ***************************************************************
  // Thread enable: host sets/clears, kill clears
  // ***************************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_r <= thread_evt_pkg::ENABLE_RST;
    end else begin
      if (host_wr && dp_addr_r == thread_evt_pkg::OFS_ENABLE) begin
        enable_r <= hwdata_i[NT-1:0];
      end
      if (do_leave && leave_kind == 3'(thread_evt_pkg::ARB_KILL)) begin
        enable_r[run_tid_r] <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Event sets and clears
  // ***************************************************************
  always_comb begin
    set_v = '0;
    clr_v = '0;
    for (int t = 0; t < NT; t++) begin
      if (done_i.valid && done_i.tid == 2'(t) &&
          done_i.event_sel < thread_evt_pkg::EV_ENQ_A)
        set_v[t*NE + int'(done_i.event_sel)] = 1'b1;
      if (cfg_r[thread_evt_pkg::CFG_FAST_PORT]) begin
        set_v[t*NE + int'(thread_evt_pkg::EV_ENQ_A)] = enq_a_i;
        set_v[t*NE + int'(thread_evt_pkg::EV_ENQ_B)] = enq_b_i;
      end
      // Host doorbell write and engine doorbell share the flag
      if ((db_wr_i && db_tid_i == 2'(t)) ||
          (host_wr && dp_addr_r == thread_evt_pkg::OFS_DOORBELL &&
           hwdata_i[1:0] == 2'(t)))
        set_v[t*NE + int'(thread_evt_pkg::EV_DOORBELL)] = 1'b1;
      if (rx_done_i && rx_tid_i == 2'(t))
        set_v[t*NE + int'(thread_evt_pkg::EV_RX_DONE)] = 1'b1;
      if (cfg_r[thread_evt_pkg::CFG_AUTOPUSH] && push_done_i &&
          rx_sched_tid_r == 2'(t))
        set_v[t*NE + int'(thread_evt_pkg::EV_PUSH)] = 1'b1;
      // Host writes a one to clear, engine gives a clear mask
      if (host_wr && dp_addr_r == thread_evt_pkg::OFS_EVT0 + 8'(4*t))
        clr_v[t*NE +: NE] = hwdata_i[NE-1:0];
      if (evt_wr_i && evt_wr_tid_i == 2'(t))
        clr_v[t*NE +: NE] = clr_v[t*NE +: NE] | evt_wr_clr_i;
      // Wake consumes the single awaited flag
      if (state_r[t] == thread_evt_pkg::TS_SLEEP &&
          wait_evt_r[t] < thread_evt_pkg::EV_NONE &&
          flags[t*NE + int'(wait_evt_r[t])])
        clr_v[t*NE + int'(wait_evt_r[t])] = 1'b1;
    end
    if (br_taken_o)
      clr_v[int'(run_tid_r)*NE + int'(cmd_i.br_event)] = 1'b1;
  end

  thread_event_flags #(
    .NT (NT),
    .NE (NE)
  ) u_flags (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .set_i    (set_v),
    .clr_i    (clr_v),
    .flags_o  (flags)
  );

  assign br_taken_o = run_vld_r & cmd_i.valid & cmd_i.br_test &
                      (cmd_i.br_event < thread_evt_pkg::EV_NONE) &
                      flags[int'(run_tid_r)*NE + int'(cmd_i.br_event)];

  // ***************************************************************
  // Context change decision
  // ***************************************************************
  // A deferred request leaves after exactly one more instruction
  always_comb begin
    do_leave   = 1'b0;
    leave_kind = 3'(thread_evt_pkg::ARB_NONE);
    leave_evt  = thread_evt_pkg::EV_NONE;
    if (run_vld_r && defer_pend_r) begin
      do_leave   = 1'b1;
      leave_kind = defer_kind_r;
      leave_evt  = defer_evt_r;
    end else if (run_vld_r && cmd_i.valid && !cmd_i.defer1 &&
                 cmd_i.kind != thread_evt_pkg::ARB_NONE) begin
      do_leave   = 1'b1;
      leave_kind = 3'(cmd_i.kind);
      leave_evt  = cmd_i.event_sel;
    end
  end

  // Candidates: ready and enabled, excluding the one leaving
  always_comb begin
    for (int t = 0; t < NT; t++) begin
      cand[t] = enable_r[t] &&
                state_r[t] == thread_evt_pkg::TS_READY;
    end
  end

  rr_picker #(
    .N (NT),
    .W (2)
  ) u_pick (
    .req_i  (cand),
    .last_i (run_tid_r),
    .any_o  (pick_any),
    .pick_o (pick_tid)
  );

  // Voluntary with nobody ready keeps the same thread running
  assign yield_ok = leave_kind != 3'(thread_evt_pkg::ARB_VOLUNTARY) ||
                    pick_any;
  assign switch_o = (do_leave && yield_ok) || (!run_vld_r && pick_any);

  // ***************************************************************
  // Per-thread state: sleeping threads wait on one event
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < NT; g++) begin : g_thr
      always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
          state_r[g]    <= thread_evt_pkg::TS_READY;
          wait_evt_r[g] <= thread_evt_pkg::EV_NONE;
        end else if (switch_o && pick_tid == 2'(g) && pick_any) begin
          state_r[g] <= thread_evt_pkg::TS_RUN;
        end else if (do_leave && yield_ok && run_tid_r == 2'(g)) begin
          // A killed thread parks ready; its cleared enable keeps it out
          if (leave_kind == 3'(thread_evt_pkg::ARB_VOLUNTARY) ||
              leave_kind == 3'(thread_evt_pkg::ARB_KILL)) begin
            state_r[g] <= thread_evt_pkg::TS_READY;
          end else begin
            state_r[g]    <= thread_evt_pkg::TS_SLEEP;
            wait_evt_r[g] <= leave_evt;
          end
        end else if (state_r[g] == thread_evt_pkg::TS_SLEEP &&
                     wait_evt_r[g] < thread_evt_pkg::EV_NONE &&
                     flags[g*NE + int'(wait_evt_r[g])]) begin
          state_r[g] <= thread_evt_pkg::TS_READY;
        end
      end
    end
  endgenerate

  // Running pointer moves on the switch edge, so overhead stays one cycle
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_tid_r <= 2'h0;
      run_vld_r <= 1'b0;
    end else if (switch_o) begin
      run_tid_r <= pick_any ? pick_tid : run_tid_r;
      run_vld_r <= pick_any;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      defer_pend_r <= 1'b0;
      defer_kind_r <= 3'h0;
      defer_evt_r  <= 4'h0;
    end else if (defer_pend_r) begin
      defer_pend_r <= 1'b0;
    end else begin
      defer_pend_r <= run_vld_r & cmd_i.valid & cmd_i.defer1 &
                      (cmd_i.kind == thread_evt_pkg::ARB_EVENT ||
                       cmd_i.kind == thread_evt_pkg::ARB_VOLUNTARY ||
                       cmd_i.kind == thread_evt_pkg::ARB_KILL);
      defer_kind_r <= 3'(cmd_i.kind);
      defer_evt_r  <= cmd_i.event_sel;
    end
  end

  assign run_vld_o = run_vld_r;
  assign run_tid_o = run_tid_r;

  // ***************************************************************
  // Checks
  // ***************************************************************
  AST_KILL_CLEARS_ENABLE: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (do_leave && leave_kind == 3'(thread_evt_pkg::ARB_KILL) && !host_wr)
    |=> !enable_r[$past(run_tid_r)])
    else $error("kill did not clear enable");

  AST_PICK_ENABLED: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (switch_o && pick_any) |-> enable_r[pick_tid])
    else $error("disabled thread picked");

  AST_VOL_STAYS: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (do_leave && leave_kind == 3'(thread_evt_pkg::ARB_VOLUNTARY) &&
     !pick_any) |=> run_vld_r && run_tid_r == $past(run_tid_r))
    else $error("voluntary lost thread");

  assign both_v = set_v & clr_v;
  assign br_idx = int'(run_tid_r) * NE + int'(cmd_i.br_event);

  AST_SET_WINS: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (|both_v) |=> (flags & $past(both_v)) == $past(both_v))
    else $error("clear beat arrival");

  AST_BR_CLEARS: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (br_taken_o && !set_v[br_idx]) |=> !flags[$past(br_idx)])
    else $error("branch did not clear flag");

  AST_DEFER_ONE: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (run_vld_r && cmd_i.valid && cmd_i.defer1 && !defer_pend_r &&
     cmd_i.kind inside {thread_evt_pkg::ARB_EVENT,
                        thread_evt_pkg::ARB_VOLUNTARY})
    |-> !switch_o ##1 do_leave)
    else $error("defer slot wrong");

  AST_DOORBELL: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    db_wr_i |=> flags[int'($past(db_tid_i))*NE +
                      int'(thread_evt_pkg::EV_DOORBELL)])
    else $error("doorbell not set");

  AST_SLEEP_WAIT: assert property (@(posedge clk_i)
    disable iff (!arst_n_i)
    (do_leave && yield_ok && leave_kind == 3'(thread_evt_pkg::ARB_EVENT)
     && !(pick_any && pick_tid == run_tid_r))
    |=> state_r[$past(run_tid_r)] == thread_evt_pkg::TS_SLEEP)
    else $error("event arbitrate did not sleep");

  COV_SWITCH: cover property (@(posedge clk_i) switch_o && run_vld_r);
  COV_KILL: cover property (@(posedge clk_i)
    do_leave && leave_kind == 3'(thread_evt_pkg::ARB_KILL));
  COV_BR: cover property (@(posedge clk_i) br_taken_o);

endmodule
`default_nettype wire

// ==== thread_switch_event_tracker_tb_top.sv ====
// Self-checking bench for the thread switch and event tracker.
// Assumes zero-wait AHB slave and a unit model on the completion port.
`timescale 1ns/100ps
`default_nettype none
module thread_switch_event_tracker_tb_top;
  logic                       clk_i = 1'b0;
  logic                       arst_n_i = 1'b0;
  logic                       hsel, hwrite, hready, hresp;
  logic [7:0]                 haddr;
  logic [1:0]                 htrans, db_tid, rx_tid, evt_wr_tid, run_tid;
  logic [2:0]                 hsize;
  logic [31:0]                hwdata, hrdata, seed = 32'hd1f2c4dd;
  logic                       enq_a, enq_b, db_wr, rx_done, push_done;
  logic                       evt_wr, run_vld, switch_w, br_taken;
  logic                       sw_s, bt_s;
  logic [1:0]                 tid_s, dbt, rxt, pst;
  logic [9:0]                 evt_wr_clr;
  logic [3:0]                 udly, ev;
  thread_evt_pkg::ctx_cmd_t   cmd;
  thread_evt_pkg::unit_done_t ureq, done;
  int                         fail_count = 0, checks_done = 0, n;
  always #2 clk_i = ~clk_i;
  thread_switch_event_tracker DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .cmd_i(cmd), .done_i(done), .enq_a_i(enq_a), .enq_b_i(enq_b),
    .db_wr_i(db_wr), .db_tid_i(db_tid), .rx_done_i(rx_done),
    .rx_tid_i(rx_tid), .push_done_i(push_done), .evt_wr_i(evt_wr),
    .evt_wr_tid_i(evt_wr_tid), .evt_wr_clr_i(evt_wr_clr),
    .run_vld_o(run_vld), .run_tid_o(run_tid), .switch_o(switch_w),
    .br_taken_o(br_taken));
  unit_model unit (.clk_i(clk_i), .arst_n_i(arst_n_i), .req_i(ureq),
    .dly_i(udly), .done_o(done));
  // ************************************************
  // Helpers
  // ************************************************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic thread_evt_pkg::ctx_cmd_t mk(
      input thread_evt_pkg::arb_kind_t k, input logic [3:0] e,
      input logic df, input logic bt);
    mk = '0;
    mk.valid = 1'b1;
    mk.kind = k;
    mk.event_sel = e;
    mk.defer1 = df;
    mk.br_test = bt;
    mk.br_event = e;
  endfunction
  // Flags expected after the mixed event burst
  function automatic logic [31:0] efl(input int i);
    efl = 32'h30 | (i == dbt || i == (dbt ^ 2'h3) ? 32'h40 : 32'h0)
        | (i == rxt ? 32'h80 : 32'h0) | (i == pst ? 32'h100 : 32'h0)
        | (i == 0 ? 32'h1 : 32'h0);
  endfunction
  task automatic tally_and_finish;
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bail;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    tally_and_finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) bail;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask
  task automatic instr(input thread_evt_pkg::ctx_cmd_t c);
    cmd <= c;
    #1 sw_s = switch_w;
    bt_s = br_taken;
    @(posedge clk_i);
    cmd <= '0;
    #1 tid_s = run_tid;
    @(posedge clk_i);
  endtask
  task automatic unit_ref(input logic [3:0] e);
    ureq <= '{1'b1, e, 2'h0};
    udly <= 4'(rnd() & 32'h7);
    @(posedge clk_i);
    ureq <= '0;
    n = 0;
    while (done.valid !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (done.valid !== 1'b1) bail;
    repeat (2) @(posedge clk_i);
  endtask
  // ************************************************
  // Main sequence
  // ************************************************
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, cmd, ureq, udly} = '0;
    {enq_a, enq_b, db_wr, db_tid, rx_done, rx_tid, push_done} = '0;
    {evt_wr, evt_wr_tid, evt_wr_clr} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd_chk(thread_evt_pkg::OFS_ENABLE, 32'h0);
    rd_chk(thread_evt_pkg::OFS_STATUS, 32'h0);
    rd_chk(8'h40, 32'h0);
    wr(thread_evt_pkg::OFS_ENABLE, 32'h1);
    // The first thread starts one cycle after its enable lands
    @(posedge clk_i);
    rd_chk(thread_evt_pkg::OFS_STATUS, 32'h4);
    chk({hresp, run_vld}, 2'h1);
    wr(thread_evt_pkg::OFS_ENABLE, 32'h3);
    for (int i = 0; i < 2; i++) begin
      ev = i ? thread_evt_pkg::EV_MEM_A : thread_evt_pkg::EV_DMA;
      instr(mk(i ? thread_evt_pkg::ARB_SWAP : thread_evt_pkg::ARB_EVENT,
               ev, 1'b0, 1'b0));
      chk({sw_s, tid_s}, 3'h5);
      instr(mk(thread_evt_pkg::ARB_VOLUNTARY, ev, 1'b0, 1'b0));
      chk(tid_s, 2'h1);
      unit_ref(ev);
      instr(mk(thread_evt_pkg::ARB_VOLUNTARY, ev, 1'b0, 1'b0));
      chk({sw_s, tid_s}, 3'h4);
      rd_chk(thread_evt_pkg::OFS_EVT0, 32'h0);
    end
    unit_ref(thread_evt_pkg::EV_FBI);
    rd_chk(thread_evt_pkg::OFS_EVT0, 32'h1);
    chk(run_tid, 2'h0);
    instr(mk(thread_evt_pkg::ARB_KILL, 4'h9, 1'b0, 1'b0));
    chk(tid_s, 2'h1);
    rd_chk(thread_evt_pkg::OFS_ENABLE, 32'h2);
    wr(thread_evt_pkg::OFS_ENABLE, 32'h3);
    cmd <= mk(thread_evt_pkg::ARB_VOLUNTARY, 4'h9, 1'b1, 1'b0);
    #1 sw_s = switch_w;
    @(posedge clk_i);
    cmd <= mk(thread_evt_pkg::ARB_NONE, 4'h9, 1'b0, 1'b0);
    #1 chk({sw_s, switch_w}, 2'h1);
    @(posedge clk_i);
    cmd <= '0;
    #1 chk(run_tid, 2'h0);
    dbt = 2'(rnd());
    rxt = 2'(rnd());
    pst = 2'(rnd());
    @(posedge clk_i);
    enq_a <= 1'b1;
    @(posedge clk_i);
    enq_a <= 1'b0;
    wr(thread_evt_pkg::OFS_CONFIG, {pst, 2'h3});
    {enq_a, enq_b, push_done, rx_done, rx_tid, db_wr, db_tid} <=
      {4'hf, rxt, 1'b1, dbt ^ 2'h3};
    @(posedge clk_i);
    {enq_a, enq_b, push_done, rx_done, db_wr} <= 5'h0;
    wr(thread_evt_pkg::OFS_DOORBELL, dbt);
    for (int i = 0; i < 4; i++) begin
      rd_chk(thread_evt_pkg::OFS_EVT0 + 8'(4 * i), efl(i));
    end
    instr(mk(thread_evt_pkg::ARB_NONE, thread_evt_pkg::EV_ENQ_A, 1'b0, 1'b1));
    chk({bt_s, tid_s}, 3'h4);
    instr(mk(thread_evt_pkg::ARB_NONE, thread_evt_pkg::EV_ENQ_A, 1'b0, 1'b1));
    chk(bt_s, 1'b0);
    rd_chk(thread_evt_pkg::OFS_EVT0, efl(0) & ~32'h10);
    for (int i = 0; i < 4; i++) begin
      wr(thread_evt_pkg::OFS_EVT0 + 8'(4 * i), 32'h3ff);
      rd_chk(thread_evt_pkg::OFS_EVT0 + 8'(4 * i), 32'h0);
    end
    {rx_done, rx_tid, evt_wr, evt_wr_tid, evt_wr_clr} <=
      {1'b1, 2'h2, 1'b1, 2'h2, 10'h3ff};
    @(posedge clk_i);
    {rx_done, evt_wr} <= 2'h0;
    rd_chk(thread_evt_pkg::OFS_EVT0 + 8'h8, 32'h80);
    evt_wr <= 1'b1;
    @(posedge clk_i);
    evt_wr <= 1'b0;
    rd_chk(thread_evt_pkg::OFS_EVT0 + 8'h8, 32'h0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// ==== unit_model.sv ====
// Stand-in for a shared functional unit answering one reference.
// Assumes the bench raises req_i for one cycle while the unit is idle.
`timescale 1ns/100ps
`default_nettype none
module unit_model (
  input  wire logic                       clk_i,    // Core clock
  input  wire logic                       arst_n_i, // Async reset
  input  wire thread_evt_pkg::unit_done_t req_i,    // New reference
  input  wire logic [3:0]                 dly_i,    // Answer delay
  output var  thread_evt_pkg::unit_done_t done_o    // Completion pulse
);
  thread_evt_pkg::unit_done_t pend_r;
  logic [3:0]                 cnt_r;
  // ************************************************
  // One reference in flight, so never two of a kind
  // ************************************************
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pend_r <= '0;
      cnt_r  <= 4'h0;
      done_o <= '0;
    end else begin
      done_o <= '0;
      if (req_i.valid && !pend_r.valid) begin
        pend_r <= req_i;
        cnt_r  <= dly_i;
      end else if (pend_r.valid && cnt_r == 4'h0) begin
        done_o <= pend_r;
        pend_r <= '0;
      end else if (pend_r.valid) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule
`default_nettype wire
